// *** hw/cpu_power_modes.sv ***
// CPU idle and stop power mode controller with clock gates and wake logic
// How it works
// [R1] Idle starts only after the instruction writing the idle bit retires.
// [R2] Idle only gates the CPU clock; no register is altered.
// [R3] Peripheral clock enable stays high throughout idle.
// [R4] Idle ends on an enabled interrupt or any reset.
// [R5] Interrupt wake clears the idle bit and restarts the CPU.
// [R6] CPU resumes at the instruction after the one that requested idle.
// [R7] Reset during idle runs a normal reset and fetches from the reset vector.
// [R8] Watchdog keeps its clock in idle and its expiry resets the device.
// [R9] Software disables the watchdog first if idle must last indefinitely.
// [R10] Stop starts only after the instruction writing the stop bit retires.
// [R11] Stop halts oscillator, CPU and digital peripherals; external oscillator untouched.
// [R12] In stop only the missing clock detector stays live; analog enables hold.
// [R13] Stop ends only by reset, then execution restarts at the reset vector.
// [R14] An enabled missing clock detector sees the halt and requests reset.
// [R15] Software disables the detector for stops longer than its timeout.
// [R16] Stop select bit reads back as zero.
// [R17] Idle select bit reads back as zero.
// [R18] Wake request needs a pending flag, its own enable and the global enable.
`timescale 1ns/1ps
module cpu_power_modes #(
   parameter int IRQ_N = pwr_mode_pkg::IRQ_N
) (
   input wire logic ref_clk, // System clock
   input wire logic rstn, // Any device reset, active low
   input wire logic ctrl_wr, // Core writes the power control register
   input wire logic [7:0] ctrl_wdata, // Write data
   input wire logic instr_done, // Current instruction retires this cycle
   input wire logic [IRQ_N-1:0] irq_pend, // Pending interrupt flags
   input wire logic [IRQ_N-1:0] irq_en, // Per-source enables
   input wire logic irq_global_en, // Global interrupt enable
   input wire logic wdt_expire, // Watchdog timer expiry pulse
   input wire logic mcd_enable, // Missing clock detector enabled
   output logic [7:0] ctrl_rdata, // Power control register readback
   output logic cpu_clk_en, // Gate for the CPU clock
   output logic periph_clk_en, // Gate for digital peripheral clocks
   output logic int_osc_en, // Internal oscillator run enable
   output logic wake_irq, // One-cycle pulse: idle ended by interrupt
   output logic reset_req, // Internal reset request to reset logic
   output logic [15:0] fetch_addr_on_reset, // Vector fetched after reset
   output logic idle_active, // Device is idle
   output logic stop_active // Device is stopped
);
   pwr_mode_pkg::pmode_t mode_reg;
   logic [7:0] flags_reg;
   logic idle_req_reg;
   logic stop_req_reg;
   logic wake_next;
   logic [$clog2(pwr_mode_pkg::DETECT_CYCLES+1)-1:0] mcd_cnt_reg;
   logic [7:0] ctrl_rdata_next;
   logic [$clog2(pwr_mode_pkg::DETECT_CYCLES+1)-1:0] stop_watch_reg;
   // Margin below the detector timeout in which no detector reset may appear
   localparam int MCD_QUIET = pwr_mode_pkg::DETECT_CYCLES - 2;

   // Wake request from qualified pending interrupts
   assign wake_next = irq_global_en && |(irq_pend & irq_en); // [R18]

   // Mode select bits are write-only; only the general flags read back
   always_comb begin
      ctrl_rdata_next = flags_reg;
      ctrl_rdata_next[pwr_mode_pkg::IDLE_BIT] = 1'b0; // [R17]
      ctrl_rdata_next[pwr_mode_pkg::STOP_BIT] = 1'b0; // [R16]
   end

   // Mode bits latched on write, acted on once the writing instruction retires
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         idle_req_reg <= 1'b0;
         stop_req_reg <= 1'b0;
         flags_reg <= pwr_mode_pkg::CTRL_RST;
      end else if (ctrl_wr && mode_reg == pwr_mode_pkg::RUN) begin
         flags_reg <= ctrl_wdata;
         idle_req_reg <= ctrl_wdata[pwr_mode_pkg::IDLE_BIT];
         stop_req_reg <= ctrl_wdata[pwr_mode_pkg::STOP_BIT];
      end else if (instr_done || mode_reg != pwr_mode_pkg::RUN) begin
         idle_req_reg <= 1'b0; // [R5]
         stop_req_reg <= 1'b0;
      end
   end

   // Mode sequencing: stop beats idle when both bits are written together
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mode_reg <= pwr_mode_pkg::RUN; // [R7] [R13]
      end else begin
         unique case (mode_reg)
            pwr_mode_pkg::RUN: begin
               if (instr_done && stop_req_reg) begin
                  mode_reg <= pwr_mode_pkg::STOP; // [R10]
               end else if (instr_done && idle_req_reg) begin
                  mode_reg <= pwr_mode_pkg::IDLE; // [R1]
               end
            end
            pwr_mode_pkg::IDLE: begin
               if (wake_next) begin
                  mode_reg <= pwr_mode_pkg::RUN; // [R4] [R5] [R6]
               end
            end
            pwr_mode_pkg::STOP: begin
               mode_reg <= pwr_mode_pkg::STOP; // [R13]
            end
            default: mode_reg <= pwr_mode_pkg::RUN;
         endcase
      end
   end

   // Missing clock detector: counts while the system clock is halted
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mcd_cnt_reg <= '0;
      end else if (mode_reg == pwr_mode_pkg::STOP && mcd_enable) begin
         if (mcd_cnt_reg != ($bits(mcd_cnt_reg))'(pwr_mode_pkg::DETECT_CYCLES)) begin
            mcd_cnt_reg <= mcd_cnt_reg + 1'b1; // [R14]
         end
      end else begin
         mcd_cnt_reg <= '0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reset_req <= 1'b0;
         wake_irq <= 1'b0;
      end else begin
         // Watchdog acts in run and idle only; in stop it is already halted
         reset_req <= (wdt_expire && mode_reg != pwr_mode_pkg::STOP) // [R8] [R12]
            || (mode_reg == pwr_mode_pkg::STOP && mcd_enable
            && mcd_cnt_reg == ($bits(mcd_cnt_reg))'(pwr_mode_pkg::DETECT_CYCLES)); // [R14]
         wake_irq <= mode_reg == pwr_mode_pkg::IDLE && wake_next; // [R5]
      end
   end

   // Every gate and status output leaves a flip-flop, one edge after the mode
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cpu_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         int_osc_en <= 1'b1;
         idle_active <= 1'b0;
         stop_active <= 1'b0;
         ctrl_rdata <= pwr_mode_pkg::CTRL_RST;
         fetch_addr_on_reset <= pwr_mode_pkg::RESET_VECTOR;
      end else begin
         cpu_clk_en <= mode_reg == pwr_mode_pkg::RUN; // [R2]
         periph_clk_en <= mode_reg != pwr_mode_pkg::STOP; // [R3] [R11]
         int_osc_en <= mode_reg != pwr_mode_pkg::STOP; // [R11]
         idle_active <= mode_reg == pwr_mode_pkg::IDLE;
         stop_active <= mode_reg == pwr_mode_pkg::STOP;
         ctrl_rdata <= ctrl_rdata_next; // [R16] [R17]
         fetch_addr_on_reset <= pwr_mode_pkg::RESET_VECTOR; // [R7]
      end
   end

   // Assertion helper: cycles seen stopped with the detector on, counted from outputs
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         stop_watch_reg <= '0;
      end else if (stop_active && mcd_enable) begin
         if (stop_watch_reg != ($bits(stop_watch_reg))'(pwr_mode_pkg::DETECT_CYCLES)) begin
            stop_watch_reg <= stop_watch_reg + 1'b1;
         end
      end else begin
         stop_watch_reg <= '0;
      end
   end

   // Multi-step entry behaviour built from named sequences
   sequence s_stop_req;
      mode_reg == pwr_mode_pkg::RUN && stop_req_reg && instr_done;
   endsequence
   sequence s_halted;
      ##1 mode_reg == pwr_mode_pkg::STOP ##1 (!cpu_clk_en && !periph_clk_en && !int_osc_en);
   endsequence
   sequence s_idle_req;
      mode_reg == pwr_mode_pkg::RUN && idle_req_reg && !stop_req_reg && instr_done;
   endsequence
   sequence s_gated;
      ##1 mode_reg == pwr_mode_pkg::IDLE ##1 !cpu_clk_en;
   endsequence


   // Idle entry, residency and wake
   AST_IDLE_ENTRY: assert property (@(posedge ref_clk) disable iff (!rstn) // [R1]
      s_idle_req |-> s_gated) else $error("idle not entered after retire");
   AST_NO_EARLY: assert property (@(posedge ref_clk) disable iff (!rstn) // [R1]
      mode_reg == pwr_mode_pkg::RUN && !instr_done |=> mode_reg == pwr_mode_pkg::RUN)
      else $error("mode left run without retire");
   AST_PERIPH_IDLE: assert property (@(posedge ref_clk) disable iff (!rstn) // [R3]
      mode_reg == pwr_mode_pkg::IDLE |=> periph_clk_en) else $error("periph gated in idle");
   AST_WAKE: assert property (@(posedge ref_clk) disable iff (!rstn) // [R4]
      mode_reg == pwr_mode_pkg::IDLE && wake_next |=> mode_reg == pwr_mode_pkg::RUN && wake_irq)
      else $error("idle wake missed");
   AST_NO_WAKE_DIS: assert property (@(posedge ref_clk) disable iff (!rstn) // [R18]
      mode_reg == pwr_mode_pkg::IDLE && !irq_global_en |=> mode_reg == pwr_mode_pkg::IDLE)
      else $error("disabled interrupt ended idle");
   AST_WDT: assert property (@(posedge ref_clk) disable iff (!rstn) // [R8]
      mode_reg == pwr_mode_pkg::IDLE && wdt_expire |=> reset_req) else $error("watchdog lost");
   AST_WAKE_RESUME: assert property (@(posedge ref_clk) disable iff (!rstn) // [R6]
      mode_reg == pwr_mode_pkg::IDLE && wake_next |=> ##1 cpu_clk_en && !idle_active)
      else $error("cpu clock not restored after wake");
   AST_IDLE_KEEP: assert property (@(posedge ref_clk) disable iff (!rstn) // [R2]
      mode_reg != pwr_mode_pkg::RUN |=> $stable(flags_reg))
      else $error("flags altered in low power");

   // Stop entry, residency and the detector
   AST_STOP_ENTRY: assert property (@(posedge ref_clk) disable iff (!rstn) // [R10]
      s_stop_req |-> s_halted) else $error("stop not entered after retire");
   AST_STOP_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn) // [R13]
      mode_reg == pwr_mode_pkg::STOP |=> mode_reg == pwr_mode_pkg::STOP && !int_osc_en)
      else $error("stop left without reset");
   AST_STOP_NO_WDT: assert property (@(posedge ref_clk) disable iff (!rstn) // [R12]
      mode_reg == pwr_mode_pkg::STOP && wdt_expire && !mcd_enable |=> !reset_req)
      else $error("watchdog acted in stop");
   AST_STOP_NO_IRQ: assert property (@(posedge ref_clk) disable iff (!rstn) // [R12]
      stop_active |-> !wake_irq) else $error("interrupt woke stop");
   AST_MCD: assert property (@(posedge ref_clk) disable iff (!rstn) // [R14]
      stop_watch_reg == ($bits(stop_watch_reg))'(pwr_mode_pkg::DETECT_CYCLES)
      |-> ##[0:2] reset_req) else $error("detector did not reset");
   AST_MCD_QUIET: assert property (@(posedge ref_clk) disable iff (!rstn) // [R14]
      stop_active && stop_watch_reg < MCD_QUIET |-> !reset_req)
      else $error("detector reset too early");

   // Readback
   AST_READ_ZERO: assert property (@(posedge ref_clk) disable iff (!rstn) // [R16] [R17]
      !ctrl_rdata[pwr_mode_pkg::IDLE_BIT] && !ctrl_rdata[pwr_mode_pkg::STOP_BIT])
      else $error("mode bits read nonzero");
endmodule

// *** hw/pwr_mode_pkg.sv ***
// Constants for the CPU idle and stop power mode controller
package pwr_mode_pkg;
   localparam int CTRL_W = 8;
   localparam int IDLE_BIT = 0;
   localparam int STOP_BIT = 1;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam int CLK_MHZ = 40;
   localparam int DETECT_TIMEOUT_US = 100;
   localparam int DETECT_CYCLES = DETECT_TIMEOUT_US * CLK_MHZ;
   localparam int IRQ_N = 8;
   typedef enum logic [1:0] {RUN, IDLE, STOP} pmode_t;
endpackage

// *** testbench/core_model.sv ***
// Core model: one power control write, retired on the following cycle
`timescale 1ns/1ps
module core_model (
   input wire logic ref_clk, // System clock
   input wire logic go, // Run one write instruction
   input wire logic [7:0] wdata, // Value the instruction writes
   output logic ctrl_wr, // Write strobe
   output logic [7:0] ctrl_wdata, // Write data
   output logic instr_done // Retire strobe
);
   // Write first, retire one cycle later, as the core pipeline does
   initial begin
      ctrl_wr = 1'b0;
      ctrl_wdata = 8'h00;
      instr_done = 1'b0;
      forever begin
         @(posedge ref_clk);
         instr_done <= ctrl_wr;
         ctrl_wr <= go;
         if (go) ctrl_wdata <= wdata;
      end
   end
endmodule

// *** testbench/test_cpu_power_modes.sv ***
// Bench for the CPU idle and stop power mode controller
`timescale 1ns/1ps
module test_cpu_power_modes;
   logic ref_clk = 1'b0, rstn = 1'b0, go = 1'b0, wdt_expire = 1'b0, mcd_enable = 1'b0;
   logic irq_global_en = 1'b0, ctrl_wr, instr_done, cpu_clk_en, periph_clk_en, int_osc_en;
   logic wake_irq, reset_req, idle_active, stop_active;
   logic [7:0] irq_pend = 8'h00, irq_en = 8'h00, wdata = 8'h00, ctrl_wdata, ctrl_rdata;
   logic [15:0] fetch_addr_on_reset;
   int fail_count = 0, check_count = 0, cyc = 0;
   initial forever #12.5 ref_clk = ~ref_clk;
   core_model core_u (.ref_clk(ref_clk), .go(go), .wdata(wdata), .ctrl_wr(ctrl_wr),
      .ctrl_wdata(ctrl_wdata), .instr_done(instr_done));
   cpu_power_modes dut_u (.ref_clk(ref_clk), .rstn(rstn), .ctrl_wr(ctrl_wr),
      .ctrl_wdata(ctrl_wdata), .instr_done(instr_done), .irq_pend(irq_pend), .irq_en(irq_en),
      .irq_global_en(irq_global_en), .wdt_expire(wdt_expire), .mcd_enable(mcd_enable),
      .ctrl_rdata(ctrl_rdata), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
      .int_osc_en(int_osc_en), .wake_irq(wake_irq), .reset_req(reset_req),
      .fetch_addr_on_reset(fetch_addr_on_reset), .idle_active(idle_active),
      .stop_active(stop_active));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic issue(input logic [7:0] d);
      wdata = d;
      go = 1'b1;
      step(1);
      go = 1'b0;
      step(6);
   endtask
   task automatic do_reset;
      rstn = 1'b0;
      step(3);
      rstn = 1'b1;
      step(1);
      chk(fetch_addr_on_reset, 16'h0000);
      chk(16'({cpu_clk_en, idle_active, stop_active}), 16'h0004);
   endtask
   task automatic test_idle;
      irq_pend = 8'h04;
      irq_en = 8'h08;
      irq_global_en = 1'b1;
      issue(8'hA5);
      chk(16'(ctrl_rdata), 16'h00A4);
      chk(16'({idle_active, cpu_clk_en, periph_clk_en, int_osc_en}), 16'h000B);
      step(40);
      chk(16'({idle_active, wake_irq}), 16'h0002);
      irq_en = 8'h0C;
      irq_global_en = 1'b0;
      step(4);
      chk(16'({idle_active, wake_irq}), 16'h0002);
      irq_global_en = 1'b1;
      for (int i = 0; i < 4 && wake_irq !== 1'b1; i++) step(1);
      chk(16'(wake_irq), 16'h0001);
      step(2);
      chk(16'({idle_active, cpu_clk_en, ctrl_rdata}), 16'h01A4);
      irq_en = 8'h00;
      $display("idle test done");
   endtask
   task automatic test_wdt;
      issue(8'h01);
      wdt_expire = 1'b1;
      step(1);
      wdt_expire = 1'b0;
      for (int i = 0; i < 4 && reset_req !== 1'b1; i++) step(1);
      chk(16'({reset_req, periph_clk_en}), 16'h0003);
      do_reset;
      $display("watchdog test done");
   endtask
   task automatic test_stop;
      issue(8'h03);
      chk(16'(ctrl_rdata), 16'h0000);
      chk(16'({stop_active, idle_active, cpu_clk_en, periph_clk_en, int_osc_en}),
         16'h0010);
      irq_pend = 8'hFF;
      irq_en = 8'hFF;
      wdt_expire = 1'b1;
      step(1);
      wdt_expire = 1'b0;
      step(4500);
      chk(16'({stop_active, wake_irq, reset_req}), 16'h0004);
      irq_pend = 8'h00;
      irq_en = 8'h00;
      do_reset;
      mcd_enable = 1'b1;
      issue(8'h02);
      step(3800);
      chk(16'(reset_req), 16'h0000);
      step(300);
      chk(16'(reset_req), 16'h0001);
      do_reset;
      $display("stop test done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         final_report;
      end
   end
   initial begin
      do_reset;
      test_idle;
      test_wdt;
      test_stop;
      final_report;
   end
endmodule
